/* hdl/tbpwm_defines.svh */
`ifndef TBPWM_DEFINES_SVH
`define TBPWM_DEFINES_SVH

// timer and duty widths
`define TBPWM_TMR_W       8
`define TBPWM_DUTY_W      10
// control register field positions
`define TBPWM_CTL_LSB_HI  5
`define TBPWM_CTL_LSB_LO  4
`define TBPWM_CTL_MODE_HI 3
`define TBPWM_CTL_MODE_LO 0
// control mode codes for pwm
`define TBPWM_MODE_PWM    4'hc
// reset values
`define TBPWM_RST_BYTE    8'h00
`define TBPWM_RST_DIR     8'hff
// pin carrying the pwm output on port c
`define TBPWM_PIN_IDX     2
// resolution cap
`define TBPWM_RES_MAX     4'ha
// postscaler terminal count
`define TBPWM_POST_LAST   4'hf

`endif

/* hdl/tbpwm_pkg.sv */
package tbpwm_pkg;

    typedef struct packed {
        logic [7:0] period;
        logic [7:0] duty_high;
        logic [7:0] control;
        logic [7:0] direction;
        logic [7:0] port_latch;
    } tbpwm_cfg_t;

    typedef struct packed {
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
    } tbpwm_pins_t;

    typedef enum logic [1:0] {
        TBPWM_IDLE = 2'b00,
        TBPWM_RUN  = 2'b01
    } tbpwm_mode_t;

endpackage : tbpwm_pkg

/* hdl/tbpwm_resol.sv */
`timescale 1ns/1ps
`include "tbpwm_defines.svh"

// ----------------------------------------
// resolution estimate: log2(fosc/fpwm)
// ----------------------------------------
module tbpwm_resol (
    // clocking
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    // period in quarter cycles minus one
    input  wire logic [9:0] period_q,
    // result
    output logic      [3:0] res_bits
);
    import tbpwm_pkg::*;

    typedef struct packed {
        logic [3:0] res;
    } tbpwm_res_st_t;

    tbpwm_res_st_t st;
    tbpwm_res_st_t next_st;
    logic [3:0]    msb;

    always_comb begin
        msb = 4'h0;
        for (int i = 0; i < 10; i++) begin
            if (period_q[i]) begin
                msb = 4'(i + 1);
            end
        end
        next_st = st;
        next_st.res = (msb > `TBPWM_RES_MAX) ? `TBPWM_RES_MAX : msb;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign res_bits = st.res;
endmodule // tbpwm_resol

/* hdl/tbpwm_core.sv */
`timescale 1ns/1ps
`include "tbpwm_defines.svh"

// Behaviour
// - timer clears after period match
// - pin set at restart unless zero duty
// - buffered duty copied at restart
// - postscaler ignored for pwm period
// - duty is buffer plus control bits
// - writes anytime, effective next period
// - active duty read only
// - active duty plus hidden latch
// - clear pin on ten bit match
// - long duty keeps pin high
// - zero control clears output latch
// - resolution is log2 capped ten
// - direction one input, zero drives

module tbpwm_core #(
    // postscaler terminal count
    parameter logic [3:0] POST_LAST = `TBPWM_POST_LAST,
    // port c pin carrying the pwm output
    parameter int         PWM_PIN   = `TBPWM_PIN_IDX
) (
    // clocking
    input  wire logic                 mclk,
    input  wire logic                 arst_n,
    input  wire logic                 clk_en,
    // timer prescale tick, quarter phase
    input  wire logic                 tmr_tick,
    input  wire logic                 tmr_on,
    input  wire logic [1:0]           q_phase,
    // software writes
    input  wire logic                 wr_period,
    input  wire logic                 wr_duty,
    input  wire logic                 wr_control,
    input  wire logic                 wr_direction,
    input  wire logic                 wr_port,
    input  wire logic [7:0]           wr_data,
    // pins
    input  wire logic [7:0]           port_c_pins_in,
    output tbpwm_pkg::tbpwm_pins_t    port_c_pins,
    // status
    output tbpwm_pkg::tbpwm_cfg_t     cfg_rd,
    output logic      [7:0]           period_timer,
    output logic      [7:0]           duty_active_high,
    output logic      [7:0]           port_c_read,
    output logic                      pwm_output_pin,
    output logic      [3:0]           res_bits,
    output logic                      postscale_event
);
    import tbpwm_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        tbpwm_cfg_t  cfg;
        tbpwm_mode_t mode;
        logic [7:0]  tmr;
        logic [7:0]  duty_act;
        logic [1:0]  duty_lsb;
        logic        out_latch;
        logic [3:0]  post_cnt;
        logic        post_ev;
        logic [7:0]  sync1;
        logic [7:0]  sync2;
    } tbpwm_st_t;

    tbpwm_st_t  st;
    tbpwm_st_t  next_st;
    logic       match;
    logic       pwm_on;
    logic [9:0] duty_full;
    logic [9:0] tmr_full;
    logic [9:0] period_q;
    logic [9:0] duty_buf;
    logic       run;
    logic       duty_hit;
    logic       pwm_pin_val;

    // ----------------------------------------
    // mode and compare
    // ----------------------------------------
    assign pwm_on = st.cfg.control[`TBPWM_CTL_MODE_HI:`TBPWM_CTL_MODE_LO]
                    == `TBPWM_MODE_PWM;
    assign run    = pwm_on && tmr_on;
    assign match  = st.tmr == st.cfg.period;
    assign tmr_full  = {st.tmr, q_phase};
    assign duty_full = {st.duty_act, st.duty_lsb};
    assign duty_hit  = run && (duty_full == tmr_full);
    assign duty_buf  = {st.cfg.duty_high,
                        st.cfg.control[`TBPWM_CTL_LSB_HI:`TBPWM_CTL_LSB_LO]};
    assign period_q  = {st.cfg.period, 2'b11};

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.post_ev = 1'b0;
        next_st.mode = pwm_on ? TBPWM_RUN : TBPWM_IDLE;
        // two flop pin synchroniser
        next_st.sync1 = port_c_pins_in;
        next_st.sync2 = st.sync1;
        if (wr_period) begin
            next_st.cfg.period = wr_data;
        end
        if (wr_duty) begin
            next_st.cfg.duty_high = wr_data;
        end
        if (wr_direction) begin
            next_st.cfg.direction = wr_data;
        end
        if (wr_port) begin
            next_st.cfg.port_latch = wr_data;
        end
        if (run) begin
            if (duty_hit) begin
                next_st.out_latch = 1'b0;
            end
            if (tmr_tick) begin
                if (match) begin
                    next_st.tmr = 8'h00;
                    next_st.duty_act = st.cfg.duty_high;
                    next_st.duty_lsb = duty_buf[1:0];
                    next_st.out_latch = (duty_buf != 10'h000);
                    next_st.post_cnt = st.post_cnt + 4'h1;
                    next_st.post_ev = st.post_cnt == POST_LAST;
                end else begin
                    next_st.tmr = st.tmr + 8'h01;
                end
            end
        end
        if (wr_control) begin
            next_st.cfg.control = wr_data;
            if (wr_data == `TBPWM_RST_BYTE) begin
                next_st.out_latch = 1'b0;
            end
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            st.cfg.direction <= `TBPWM_RST_DIR;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // pwm pin source
    // ----------------------------------------
    // output latch in pwm mode, port data otherwise
    assign pwm_pin_val = (st.mode == TBPWM_RUN) ? st.out_latch
                         : st.cfg.port_latch[PWM_PIN];

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    // direction selects drive
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            if (g == PWM_PIN) begin : g_pwm
                assign port_c_pins.pin_out[g] = pwm_pin_val;
            end else begin : g_gp
                assign port_c_pins.pin_out[g] = st.cfg.port_latch[g];
            end
            assign port_c_pins.pin_oe[g] = ~st.cfg.direction[g];
        end
    endgenerate

    // ----------------------------------------
    // resolution
    // ----------------------------------------
    tbpwm_resol u_resol (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .clk_en   (clk_en),
        .period_q (period_q),
        .res_bits (res_bits)
    );

    // ----------------------------------------
    // status outputs
    // ----------------------------------------
    assign cfg_rd           = st.cfg;
    assign period_timer     = st.tmr;
    assign duty_active_high = st.duty_act;
    assign port_c_read      = st.sync2;
    assign pwm_output_pin   = st.out_latch;
    assign postscale_event  = st.post_ev;
endmodule // tbpwm_core

/* tb/tbpwm_monitor.sv */
`timescale 1ns/1ps
// ----
// pwm checker
// ----
module tbpwm_monitor (
    // watched ports
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic tmr_tick,
    input wire logic tmr_on,
    input wire logic wr_control,
    input wire logic wr_duty,
    input wire logic wr_port,
    input wire logic [7:0] wr_data,
    input wire tbpwm_pkg::tbpwm_pins_t port_c_pins,
    input wire tbpwm_pkg::tbpwm_cfg_t cfg_rd,
    input wire logic [7:0] period_timer,
    input wire logic [7:0] duty_active_high,
    input wire logic pwm_output_pin
);
    import tbpwm_pkg::*;
    wire md = cfg_rd.control[3:0] == 4'hc;
    wire go = md && clk_en && tmr_on && tmr_tick;
    wire hit = go && period_timer == cfg_rd.period;
    wire zap = clk_en && wr_control && wr_data == 8'h00;
    wire nz = {cfg_rd.duty_high, cfg_rd.control[5:4]} != 10'h000;
    wire lng = duty_active_high > cfg_rd.period;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    AST_RESTART: assert property (hit |=> period_timer == 8'h00)
        else $error("timer not cleared");
    AST_COUNT: assert property (go && !hit |=>
        period_timer == $past(period_timer) + 8'h01) else $error("bad step");
    AST_SET: assert property (hit && nz && !zap |=> pwm_output_pin)
        else $error("pin not set");
    AST_COPY: assert property (hit |=>
        duty_active_high == $past(cfg_rd.duty_high)) else $error("no copy");
    AST_CLEAR: assert property ($fell(pwm_output_pin) && $past(md)
        && !$past(wr_control) |-> $past(period_timer) ==
        $past(duty_active_high)) else $error("early clear");
    AST_ZERO: assert property (zap && !wr_port |=> !pwm_output_pin &&
        $stable(cfg_rd.port_latch)) else $error("zero control");
    AST_LONG: assert property (pwm_output_pin && md && lng && !hit
        && !wr_control && period_timer <= cfg_rd.period |=> pwm_output_pin)
        else $error("long duty cleared");
    AST_DIR: assert property ({port_c_pins.pin_oe[7:3],
        port_c_pins.pin_oe[1:0]} == ~{cfg_rd.direction[7:3],
        cfg_rd.direction[1:0]}) else $error("bad enable");
    AST_DUTY_WR: assert property (clk_en && wr_duty |=>
        cfg_rd.duty_high == $past(wr_data)) else $error("duty write");
    AST_FREEZE: assert property (!clk_en |=>
        $stable(period_timer) && $stable(pwm_output_pin))
        else $error("state moved while frozen");
    AST_STOP: assert property (clk_en && !tmr_on |=>
        $stable(period_timer)) else $error("timer moved while stopped");
endmodule // tbpwm_monitor

bind tbpwm_core tbpwm_monitor u_mon (
    .mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
    .tmr_tick(tmr_tick), .tmr_on(tmr_on),
    .wr_control(wr_control), .wr_duty(wr_duty),
    .wr_port(wr_port), .wr_data(wr_data),
    .port_c_pins(port_c_pins), .cfg_rd(cfg_rd),
    .period_timer(period_timer),
    .duty_active_high(duty_active_high),
    .pwm_output_pin(pwm_output_pin));

/* tb/tbpwm_load.sv */
`timescale 1ns/1ps
// ----
// pin load with pull-ups
// ----
module tbpwm_load (
    // pad side
    input  wire tbpwm_pkg::tbpwm_pins_t pins,
    output logic [7:0]                  level
);
    import tbpwm_pkg::*;
    // undriven pins rise to the pull-up
    assign level = (pins.pin_oe & pins.pin_out) | ~pins.pin_oe;
endmodule // tbpwm_load

/* tb/test_ten_bit_pwm_unit.sv */
`timescale 1ns/1ps
// ----
// pwm bench
// ----
module test_ten_bit_pwm_unit;
    import tbpwm_pkg::*;
    logic mclk, arst_n, tmr_tick;
    logic [1:0] q_phase = 2'h0;
    logic [4:0] wr_sel = 5'h00;
    logic [7:0] wr_data = 8'h00, pins_in, tmr, dact, prd;
    logic [3:0] res;
    logic pwm, post;
    logic en = 1'b1, ton = 1'b1;
    logic [15:0] np = 16'h0000;
    tbpwm_pins_t pins;
    tbpwm_cfg_t cfg;
    int n_errors = 0;
    int checks = 0;
    tbpwm_core i_dut (.mclk(mclk), .arst_n(arst_n), .clk_en(en),
        .tmr_tick(tmr_tick), .tmr_on(ton), .q_phase(q_phase),
        .wr_period(wr_sel[0]), .wr_duty(wr_sel[1]), .wr_control(wr_sel[2]),
        .wr_direction(wr_sel[3]), .wr_port(wr_sel[4]), .wr_data(wr_data),
        .port_c_pins_in(pins_in), .port_c_pins(pins), .cfg_rd(cfg),
        .period_timer(tmr), .duty_active_high(dact), .port_c_read(prd),
        .pwm_output_pin(pwm), .res_bits(res), .postscale_event(post));
    tbpwm_load i_load (.pins(pins), .level(pins_in));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        q_phase <= q_phase + 2'h1;
        tmr_tick <= q_phase == 2'h2;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input int s, input logic [7:0] d);
        @(posedge mclk);
        wr_sel <= 5'h01 << s;
        wr_data <= d;
        @(posedge mclk);
        wr_sel <= 5'h00;
    endtask
    task automatic t_pwm(input logic [7:0] n, input logic [9:0] d,
                         input int hi, input logic [3:0] r);
        logic [15:0] c;
        c = 16'h0000;
        wr(0, n);
        wr(1, d[9:2]);
        wr(3, 8'hfb);
        wr(2, {2'h0, d[1:0], 4'hc});
        repeat (2) @(negedge mclk);
        for (int i = 0; i < 2100 && (tmr !== 8'h00 || q_phase !== 2'h0); i++)
            @(negedge mclk);
        chk({tmr, 6'h00, q_phase}, 16'h0000);
        chk(dact, d[9:2]);
        repeat (4 * (n + 1)) begin
            c = c + 16'(pwm);
            @(negedge mclk);
        end
        chk(c, hi);
        chk(res, r);
    endtask
    task automatic t_hold(input int s);
        for (int i = 0; i < 40 && (tmr !== 8'h00 || q_phase !== 2'h0); i++)
            @(negedge mclk);
        @(posedge mclk);
        if (s == 0)
            en <= 1'b0;
        else
            ton <= 1'b0;
        repeat (8) @(negedge mclk);
        chk({tmr, 7'h00, pwm}, 16'h0001);
        @(posedge mclk);
        en <= 1'b1;
        ton <= 1'b1;
    endtask
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #2000000;
        n_errors++;
        tally_and_finish;
    end
    initial begin
        arst_n = 1'b0;
        repeat (5) @(posedge mclk);
        chk({cfg.direction, pins.pin_oe}, 16'hff00);
        arst_n <= 1'b1;
        t_pwm(8'h03, 10'h005, 6, 4'h4);
        t_pwm(8'h03, 10'h000, 0, 4'h4);
        t_pwm(8'h03, 10'h00e, 15, 4'h4);
        t_pwm(8'h03, 10'h3ff, 16, 4'h4);
        t_pwm(8'hff, 10'h200, 513, 4'ha);
        wr(4, 8'h5a);
        wr(0, 8'h03);
        wr(1, 8'hff);
        repeat (1200) @(negedge mclk);
        chk(pwm, 1'b1);
        repeat (256) begin
            np = np + 16'(post);
            @(negedge mclk);
        end
        chk(np, 16'h0001);
        t_hold(0);
        t_hold(1);
        wr(2, 8'h00);
        @(negedge mclk);
        chk({pwm, cfg.port_latch}, 9'h05a);
        wr(3, 8'h0f);
        repeat (4) @(negedge mclk);
        chk({pins.pin_oe, prd}, 16'hf05f);
        tally_and_finish;
    end
endmodule // test_ten_bit_pwm_unit
